// ==== hdl/fifo_port_if.sv ====
// Purpose: Write and read port bundle of one byte FIFO memory
// Assumes: Single clock, one write and one read per cycle
// Notes:   Read data is registered inside the memory
`timescale 1ns/1ps
`default_nettype none
interface fifo_port_if;
  logic       we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [2:0] raddr;
  logic [7:0] rdata;
  modport mem  (input we, waddr, wdata, raddr, output rdata);
  modport user (output we, waddr, wdata, raddr, input rdata);
endinterface
`default_nettype wire

// ==== hdl/spi_fifo_mem.sv ====
// Purpose: Eight-byte storage for one FIFO direction
// Assumes: Pointers are kept by the user
// Notes:   Read data comes out of a register one edge after raddr
`timescale 1ns/1ps
`default_nettype none
module spi_fifo_mem
  import spi_flags_pkg::*;
(
  input  wire logic ref_clk,
  fifo_port_if.mem  port_m
);
  logic [7:0] mem_q [0:(1<<FIFO_AW)-1];

  // Write port and registered read port
  always_ff @(posedge ref_clk) begin
    if (port_m.we) begin
      mem_q[port_m.waddr] <= port_m.wdata;
    end
    port_m.rdata <= mem_q[port_m.raddr];
  end
endmodule
`default_nettype wire

// ==== hdl/spi_fifo_status_flags.sv ====
// Purpose: SPI status flags, FIFO occupancy and a small slave shifter
// Assumes: AHB-Lite slave, pins sampled through two flops
// Notes:   FIFO flags are derived each cycle from the occupancy counters
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Mode fault bit reads 0 without error, 1 once a fault is detected.
// R2 - Rx mark clear: nearly-full when receive FIFO holds 48 bits or more.
// R3 - Rx mark set: nearly-full when receive FIFO holds 32 bits or more.
// R4 - FIFO flags meaningless and read zero while FIFO mode is off.
// R5 - Tx mark clear: nearly-empty when 16 bits or fewer remain.
// R6 - Tx mark set: nearly-empty when 32 bits or fewer remain.
// R7 - Tx full set at eight bytes held, clear below eight.
// R8 - Rx empty flag is 1 with no data, 0 with any entry.
// R9 - Data reads pop the receive FIFO: both bytes or low byte only.
// R10 - After power-on reset tx nearly-empty and rx empty read 0.
// R11 - Changing width, FIFO enable or module enable clears flags, flushes. Code: FIFO enable can only be set, and only setting it flushes.
// R12 - After that reset the two flags follow the FIFO enable value.
// R13 - Mode fault sets only as master, detect on, no SS drive, SS low.
// R14 - Each direction buffered by a 64-bit FIFO in FIFO mode.
// R15 - Flags come from occupancy counters, current within one clock.
module spi_fifo_status_flags
  import spi_flags_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        sck_in,
  input  wire logic        ss_in_n,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  output logic             irq
);
  logic [SYNC_W-1:0] pins_s;
  logic              sck_s;
  logic              ss_s_n;
  logic              mosi_s;
  logic              sck_prev_q;
  logic              ss_prev_q;
  logic              wr_pend_q;
  logic              rd_pend_q;
  logic [7:0]        addr_q;
  logic [4:0]        ctrl_q;
  logic [5:0]        fctl_q;
  logic [2:0]        irq_st_q;
  logic [2:0]        irq_en_q;
  logic              mode_fault_flag_q;
  logic              mode_fault_flag_arm_q;
  logic              cfg_seen_q;
  logic [3:0]        tx_cnt_q;
  logic [3:0]        rx_cnt_q;
  logic [2:0]        tx_wp_q;
  logic [2:0]        tx_rp_q;
  logic [2:0]        rx_wp_q;
  logic [2:0]        rx_rp_q;
  logic [7:0]        rx_sh_q;
  logic [7:0]        tx_sh_q;
  logic [2:0]        bit_q;
  logic              done_q;
  logic              rnf_prev_q;
  logic              tne_prev_q;

  fifo_port_if tx_if();
  fifo_port_if rx_if();

  // Pin synchroniser and storage
  spi_pin_sync u_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .pin_in   ({mosi_in, ss_in_n, sck_in}),
    .pin_sync (pins_s)
  );
  spi_fifo_mem u_tx_mem (.ref_clk(ref_clk), .port_m(tx_if.mem)); // R14
  spi_fifo_mem u_rx_mem (.ref_clk(ref_clk), .port_m(rx_if.mem)); // R14

  assign sck_s  = pins_s[0];
  assign ss_s_n = pins_s[1];
  assign mosi_s = pins_s[2];

  // Configuration fields
  wire module_enable     = ctrl_q[CTL_ENABLE];
  wire word_width_select = ctrl_q[CTL_WIDTH16];
  wire master            = ctrl_q[CTL_MASTER];
  wire mode_fault_flag_en           = ctrl_q[CTL_MODE_FAULT_FLAG_EN];
  wire ss_oe             = ctrl_q[CTL_SS_OE];
  wire fifo_enable       = fctl_q[FC_ENABLE];

  // Bus address phase and data phase decode
  wire        take    = hsel & htrans[1] & hready;
  wire        a_rd    = take & ~hwrite;
  wire [7:0]  a_ofs   = haddr[7:0];
  wire        w_ctrl  = wr_pend_q & (addr_q == OFS_CTRL);
  wire        w_fctl  = wr_pend_q & (addr_q == OFS_FIFO_CTRL);
  wire        w_dlow  = wr_pend_q & (addr_q == OFS_DATA_LOW);
  wire        w_dhigh = wr_pend_q & (addr_q == OFS_DATA_HIGH);
  wire        w_iclr  = wr_pend_q & (addr_q == OFS_IRQ_CLEAR);
  wire        w_ien   = wr_pend_q & (addr_q == OFS_IRQ_ENABLE);
  wire        r_flag  = a_rd & (a_ofs == OFS_FLAG_WORD);
  wire        r_data  = a_rd & ((a_ofs == OFS_DATA_LOW)
                      | ((a_ofs == OFS_DATA_HIGH) & word_width_select));

  // Configuration change that resets flags and flushes FIFOs
  wire ctrl_chg = w_ctrl & ((hwdata[CTL_ENABLE] != module_enable)
                | (hwdata[CTL_WIDTH16] != word_width_select));
  wire fctl_chg = w_fctl & hwdata[FC_ENABLE] & ~fifo_enable;
  wire cfg_chg  = ctrl_chg | fctl_chg; // R11

  // FIFO pushes and pops
  wire tx_full_raw = (tx_cnt_q == FIFO_DEPTH);
  wire rx_full_raw = (rx_cnt_q == FIFO_DEPTH);
  wire tx_push = (w_dlow | (w_dhigh & word_width_select)) & ~tx_full_raw
               & ~cfg_chg;
  wire rx_pop  = r_data & (rx_cnt_q != 4'h0) & ~cfg_chg; // R9

  // Serial edges, slave shifter active when selected and not master
  wire active   = module_enable & ~master & ~ss_s_n;
  wire sck_rise = active & sck_s & ~sck_prev_q;
  wire sck_fall = active & ~sck_s & sck_prev_q;
  wire ss_fall  = module_enable & ~master & ss_prev_q & ~ss_s_n;
  wire load_tx  = ss_fall | (sck_fall & done_q);
  wire tx_pop   = load_tx & (tx_cnt_q != 4'h0) & ~cfg_chg;
  wire byte_in  = sck_rise & (bit_q == BIT_LAST);
  wire rx_push  = byte_in & ~rx_full_raw & ~cfg_chg;

  // Memory port wiring
  assign tx_if.we    = tx_push;
  assign tx_if.waddr = tx_wp_q;
  assign tx_if.wdata = hwdata[7:0];
  assign tx_if.raddr = tx_rp_q;
  assign rx_if.we    = rx_push;
  assign rx_if.waddr = rx_wp_q;
  assign rx_if.wdata = {rx_sh_q[6:0], mosi_s};
  assign rx_if.raddr = rx_rp_q;

  // Occupancy counters feeding every FIFO flag
  wire [3:0] tx_cnt_d = cfg_chg ? 4'h0 : 4'(tx_cnt_q
                      + {3'h0, tx_push} - {3'h0, tx_pop}); // R15
  wire [3:0] rx_cnt_d = cfg_chg ? 4'h0 : 4'(rx_cnt_q
                      + {3'h0, rx_push} - {3'h0, rx_pop}); // R15 R9

  // Watermark, full and empty flags, zero outside FIFO mode
  wire [3:0] rx_mark = fctl_q[FC_RX_MARK] ? RX_MARK_HI : RX_MARK_LO; // R2 R3
  wire [3:0] tx_mark = fctl_q[FC_TX_MARK] ? TX_MARK_HI : TX_MARK_LO; // R5 R6
  wire rx_near_full_flag = fifo_enable & (rx_cnt_q >= rx_mark); // R2 R3 R4
  wire tx_nearly_empty_flag = fifo_enable & cfg_seen_q
                            & (tx_cnt_q <= tx_mark); // R5 R6 R10 R12
  wire tx_full_flag = fifo_enable & tx_full_raw; // R7 R4
  wire rx_fifo_empty_flag = fifo_enable & cfg_seen_q
                          & (rx_cnt_q == 4'h0); // R8 R10 R12
  wire mode_fault_flag = mode_fault_flag_q; // R1
  wire [7:0] flag_word = {3'h0, mode_fault_flag, rx_near_full_flag,
                          tx_nearly_empty_flag, tx_full_flag,
                          rx_fifo_empty_flag};

  // Mode fault detection condition
  wire mode_fault_flag_hit = module_enable & master & mode_fault_flag_en & ~ss_oe
                & ~ss_s_n; // R13

  // Interrupt events and sticky status, set beats clear
  wire [2:0] irq_ev = {tx_nearly_empty_flag & ~tne_prev_q,
                       rx_near_full_flag & ~rnf_prev_q,
                       mode_fault_flag_hit & ~mode_fault_flag_q};
  wire [2:0] irq_clr = w_iclr ? hwdata[2:0] : 3'h0;
  assign irq = |(irq_st_q & irq_en_q);

  // Read data selection in the data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_comb begin
    hrdata = 32'h0;
    if (rd_pend_q) begin
      case (addr_q)
        OFS_FLAG_WORD:  hrdata = {24'h0, flag_word};
        OFS_CTRL:       hrdata = {27'h0, ctrl_q};
        OFS_FIFO_CTRL:  hrdata = {26'h0, fctl_q};
        OFS_DATA_LOW:   hrdata = {24'h0, rx_if.rdata};
        OFS_DATA_HIGH:  hrdata = word_width_select
                                 ? {24'h0, rx_if.rdata} : 32'h0;
        OFS_IRQ_STATUS: hrdata = {29'h0, irq_st_q};
        OFS_IRQ_ENABLE: hrdata = {29'h0, irq_en_q};
        default:        hrdata = 32'h0;
      endcase
    end
  end

  // Bus phase tracking
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= a_rd;
      addr_q    <= a_ofs;
    end
  end

  // Software registers; FIFO control only taken when it sets enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q   <= CTL_RESET;
      fctl_q   <= FC_RESET;
      irq_en_q <= IRQ_RESET;
      irq_st_q <= IRQ_RESET;
    end else begin
      if (w_ctrl) ctrl_q <= hwdata[4:0];
      if (w_fctl & hwdata[FC_ENABLE]) fctl_q <= hwdata[5:0];
      if (w_ien) irq_en_q <= hwdata[2:0];
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
    end
  end

  // Mode fault flag: read while set arms, control write clears
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else begin
      if (mode_fault_flag_hit) begin
        mode_fault_flag_q <= 1'b1; // R13 R1
      end else if (cfg_chg | (w_ctrl & mode_fault_flag_arm_q)) begin
        mode_fault_flag_q <= 1'b0; // R11
      end
      if (r_flag & mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;
      end else if (w_ctrl | cfg_chg) begin
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // Counters, pointers and the reset-kind marker
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_q   <= 4'h0;
      rx_cnt_q   <= 4'h0;
      tx_wp_q    <= 3'h0;
      tx_rp_q    <= 3'h0;
      rx_wp_q    <= 3'h0;
      rx_rp_q    <= 3'h0;
      cfg_seen_q <= 1'b0; // R10
      rnf_prev_q <= 1'b0;
      tne_prev_q <= 1'b0;
    end else begin
      tx_cnt_q   <= tx_cnt_d;
      rx_cnt_q   <= rx_cnt_d;
      rnf_prev_q <= rx_near_full_flag;
      tne_prev_q <= tx_nearly_empty_flag;
      if (cfg_chg) begin
        cfg_seen_q <= 1'b1; // R12
        tx_wp_q    <= 3'h0; // R11
        tx_rp_q    <= 3'h0;
        rx_wp_q    <= 3'h0;
        rx_rp_q    <= 3'h0;
      end else begin
        tx_wp_q <= tx_wp_q + 3'(tx_push);
        tx_rp_q <= tx_rp_q + 3'(tx_pop);
        rx_wp_q <= rx_wp_q + 3'(rx_push);
        rx_rp_q <= rx_rp_q + 3'(rx_pop); // R9
      end
    end
  end

  // Slave shifter: sample on rise, shift out on fall, MSB first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sck_prev_q <= 1'b0;
      ss_prev_q  <= 1'b1;
      rx_sh_q    <= 8'h00;
      tx_sh_q    <= 8'h00;
      bit_q      <= 3'h0;
      done_q     <= 1'b0;
      miso_out   <= 1'b0;
      miso_oe_n  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      ss_prev_q  <= ss_s_n;
      miso_oe_n  <= ~active;
      miso_out   <= tx_sh_q[7];
      if (ss_fall) begin
        bit_q  <= 3'h0;
        done_q <= 1'b0;
      end else if (sck_rise) begin
        rx_sh_q <= {rx_sh_q[6:0], mosi_s};
        bit_q   <= bit_q + 3'h1;
        done_q  <= byte_in;
      end else if (sck_fall & done_q) begin
        done_q <= 1'b0;
      end
      if (load_tx) begin
        tx_sh_q <= tx_pop ? tx_if.rdata : 8'h00;
      end else if (sck_fall) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // Checks on the flag and FIFO behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_mode_fault_flag_set_cause: assert property ( // R13
    $rose(mode_fault_flag_q) |-> $past(master & mode_fault_flag_en & ~ss_oe & ~ss_s_n))
    else $error("mode fault set without its condition");
  a_mode_fault_flag_sticky: assert property ( // R1
    mode_fault_flag_q & ~w_ctrl & ~cfg_chg |=> mode_fault_flag_q)
    else $error("mode fault flag dropped on its own");
  a_rx_mark_low: assert property ( // R2
    fifo_enable & ~fctl_q[FC_RX_MARK] & (rx_cnt_q >= 4'h6)
    |-> flag_word[FLG_RX_NEAR])
    else $error("rx nearly full missing at six bytes");
  a_rx_mark_high: assert property ( // R3
    fifo_enable & fctl_q[FC_RX_MARK]
    |-> flag_word[FLG_RX_NEAR] == (rx_cnt_q >= 4'h4))
    else $error("rx nearly full wrong at four-byte mark");
  a_fifo_off_quiet: assert property ( // R4
    ~fifo_enable |-> flag_word[3:0] == 4'h0)
    else $error("FIFO flags active with FIFO mode off");
  a_tx_mark_low: assert property ( // R5
    fifo_enable & cfg_seen_q & ~fctl_q[FC_TX_MARK]
    |-> flag_word[FLG_TX_NEAR] == (tx_cnt_q <= 4'h2))
    else $error("tx nearly empty wrong at two-byte mark");
  a_tx_mark_high: assert property ( // R6
    fifo_enable & cfg_seen_q & fctl_q[FC_TX_MARK] & (tx_cnt_q == 4'h5)
    |-> ~flag_word[FLG_TX_NEAR])
    else $error("tx nearly empty set above four bytes");
  a_tx_full_exact: assert property ( // R7
    flag_word[FLG_TX_FULL] |-> tx_cnt_q == 4'h8 ##0 ~tx_push)
    else $error("tx full flag without eight bytes");
  a_rx_empty_flag: assert property ( // R8
    fifo_enable & cfg_seen_q & rx_push & ~rx_pop |=> ~flag_word[0])
    else $error("rx empty flag set with data held");
  a_rx_pop_count: assert property ( // R9
    rx_pop & ~rx_push |=> rx_cnt_q == $past(rx_cnt_q) - 4'h1)
    else $error("data read did not pop one byte");
  a_por_flags_low: assert property ( // R10
    ~cfg_seen_q |-> ~flag_word[FLG_TX_NEAR] & ~flag_word[0])
    else $error("flags high before any configuration reset");
  a_cfg_flush: assert property ( // R11
    cfg_chg & ~mode_fault_flag_hit |=> (tx_cnt_q == 4'h0) & (rx_cnt_q == 4'h0)
    & ~mode_fault_flag_q)
    else $error("configuration change did not flush");
  a_cfg_flags: assert property ( // R12
    cfg_chg ##1 fifo_enable |-> flag_word[FLG_TX_NEAR] & flag_word[0])
    else $error("flags not set after configuration reset");
  a_cnt_step: assert property ( // R15
    ~cfg_chg & ~tx_push & ~tx_pop |=> $stable(tx_cnt_q))
    else $error("tx occupancy moved without push or pop");
endmodule
`default_nettype wire

// ==== hdl/spi_flags_pkg.sv ====
// Purpose: Shared constants for the SPI FIFO status-flag block
// Assumes: 32-bit AHB-Lite register bus, byte-wide FIFO entries
// Notes:   Offsets are byte addresses inside the block window
package spi_flags_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAG_WORD  = 8'h00;
  localparam logic [7:0] OFS_CTRL       = 8'h04;
  localparam logic [7:0] OFS_FIFO_CTRL  = 8'h08;
  localparam logic [7:0] OFS_DATA_LOW   = 8'h0C;
  localparam logic [7:0] OFS_DATA_HIGH  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
  // Flag word bit positions
  localparam int FLG_RX_EMPTY = 0;
  localparam int FLG_TX_FULL  = 1;
  localparam int FLG_TX_NEAR  = 2;
  localparam int FLG_RX_NEAR  = 3;
  localparam int FLG_MODE_FAULT_FLAG     = 4;
  // Control register bit positions
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_WIDTH16  = 1;
  localparam int CTL_MASTER   = 2;
  localparam int CTL_MODE_FAULT_FLAG_EN  = 3;
  localparam int CTL_SS_OE    = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;
  // FIFO control bit positions
  localparam int FC_ENABLE    = 0;
  localparam int FC_RX_MARK   = 4;
  localparam int FC_TX_MARK   = 5;
  localparam logic [5:0] FC_RESET = 6'h00;
  // Interrupt bit positions
  localparam int IRQ_MODE_FAULT_FLAG     = 0;
  localparam int IRQ_RX_NEAR  = 1;
  localparam int IRQ_TX_NEAR  = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // FIFO geometry and watermarks, in bytes
  localparam int          FIFO_AW     = 3;
  localparam logic [3:0]  FIFO_DEPTH  = 4'h8;
  localparam logic [3:0]  RX_MARK_LO  = 4'h6;
  localparam logic [3:0]  RX_MARK_HI  = 4'h4;
  localparam logic [3:0]  TX_MARK_LO  = 4'h2;
  localparam logic [3:0]  TX_MARK_HI  = 4'h4;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam int          SYNC_W      = 3;
  // Idle pin levels {mosi, ss_n, sck} loaded into the synchroniser at reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 3'h2;
endpackage

// ==== hdl/spi_pin_sync.sv ====
// Purpose: Two-flop synchroniser for the serial-side pins
// Assumes: Pins are asynchronous to ref_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync
  import spi_flags_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [SYNC_W-1:0] pin_in,
  output logic      [SYNC_W-1:0] pin_sync
);
  logic [SYNC_W-1:0] meta_q;

  // Two stages, reset to the pins' idle levels so no false edge follows
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= SYNC_IDLE;
      pin_sync <= SYNC_IDLE;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== sim/spi_fifo_status_flags_bench.sv ====
// Purpose: Self-checking bench for the SPI status-flag block
// Assumes: Zero-wait AHB-Lite slave, SPI master model on the pins
// Notes:   Register reads are checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module spi_fifo_status_flags_bench
  import spi_flags_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h00000000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h00000000;
  logic        rd_ph   = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        sck;
  logic        ss_n;
  logic        mosi;
  logic        miso_out;
  logic        miso_oe_n;
  wire         miso_line;
  logic        irq;
  logic [31:0] exp_q[$];
  logic [7:0]  txb[$];
  logic [7:0]  rxb[$];
  logic [7:0]  got;
  logic [7:0]  ctl;
  int          err_total = 0;
  int          checked   = 0;

  // Bus clock, 10 ns period
  always #5 ref_clk = !ref_clk;

  // Device under test and the link master
  spi_fifo_status_flags dut (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sck_in(sck), .ss_in_n(ss_n), .mosi_in(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .irq(irq)
  );
  // Released miso line shows the inverse of the last driven level
  assign miso_line = miso_oe_n ? !miso_out : miso_out;
  spi_master_model partner (
    .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_line)
  );

  // Counts a comparison and reports a mismatch
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checked++;
    if (v !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, v, e);
    end
  endtask

  // Address phase held until hready, then the data phase
  task automatic xact(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xact(a, 1'b1, d);
  endtask

  // A read notes its expected data before the bus cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xact(a, 1'b0, 32'h00000000);
  endtask

  // Takes the oldest note when read data stands
  always @(posedge ref_clk) begin
    if (rd_ph === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h00000000);
    end
    rd_ph <= nrst && hsel && htrans[1] && !hwrite && hreadyout;
  end

  // Expected flag word from occupancy and the watermark selects
  function automatic logic [31:0] flg(int rc, int tc, logic m);
    logic [31:0] e;
    e = 32'h00000000;
    e[FLG_RX_EMPTY] = (rc == 0);
    e[FLG_TX_FULL]  = (tc == 8);
    e[FLG_TX_NEAR]  = (tc <= (m ? 4 : 2));
    e[FLG_RX_NEAR]  = (rc >= (m ? 4 : 6));
    return e;
  endfunction

  // Interrupt level once the last write has landed
  task automatic irq_is(input logic e);
    @(posedge ref_clk);
    #1 chk({31'h0, irq}, {31'h0, e});
    @(posedge ref_clk);
  endtask

  // Verdict and end of run
  task automatic stop_test;
    $display("counts: checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 15 us
  initial begin
    #200000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    stop_test;
  end

  // Main sequence
  initial begin
    void'($urandom(32'hDBC8C8AD));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_FLAG_WORD, 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000);
    ctl = 8'h01;
    wr(OFS_CTRL, {24'h0, ctl});
    wr(OFS_DATA_LOW, $urandom);
    rd(OFS_FLAG_WORD, 32'h00000000);
    irq_is(1'b0);
    $display("test power_on done");
    // Fill, shift out and drain under both watermark selects
    for (int m = 0; m < 2; m++) begin
      wr(OFS_FIFO_CTRL, m ? 32'h00000031 : 32'h00000001);
      ctl = ctl ^ 8'h02;
      wr(OFS_CTRL, {24'h0, ctl});
      rd(OFS_FLAG_WORD, 32'h00000005);
      for (int k = 1; k <= 9; k++) begin
        got = 8'($urandom);
        if (k <= 8) txb.push_back(got);
        wr((ctl[1] && k[0]) ? OFS_DATA_HIGH : OFS_DATA_LOW, {24'h0, got});
        rd(OFS_FLAG_WORD, flg(0, k > 8 ? 8 : k, m[0]));
      end
      partner.sel(1'b1);
      for (int k = 1; k <= 8; k++) begin
        rxb.push_back(8'($urandom));
        partner.xfer(rxb[k-1], got);
        chk({24'h0, got}, {24'h0, txb.pop_front()});
        repeat (6) @(posedge ref_clk);
        rd(OFS_FLAG_WORD, flg(k, k < 7 ? 7 - k : 0, m[0]));
      end
      partner.sel(1'b0);
      @(posedge ref_clk);
      for (int k = 7; k >= 0; k--) begin
        rd((ctl[1] && k[0]) ? OFS_DATA_HIGH : OFS_DATA_LOW,
           {24'h0, rxb.pop_front()});
        rd(OFS_FLAG_WORD, flg(k, 0, m[0]));
      end
      $display("test fifo pass %0d done", m);
    end
    // Mode fault with interrupt raise, mask and clear
    rd(OFS_IRQ_STATUS, 32'h00000006);
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    wr(OFS_IRQ_ENABLE, 32'h00000001);
    partner.sel(1'b1);
    @(posedge ref_clk);
    wr(OFS_CTRL, 32'h0000001D);
    repeat (6) @(posedge ref_clk);
    rd(OFS_FLAG_WORD, 32'h00000005);
    irq_is(1'b0);
    wr(OFS_CTRL, 32'h0000000D);
    repeat (6) @(posedge ref_clk);
    rd(OFS_IRQ_STATUS, 32'h00000001);
    irq_is(1'b1);
    wr(OFS_IRQ_ENABLE, 32'h00000000);
    irq_is(1'b0);
    wr(OFS_IRQ_ENABLE, 32'h00000001);
    partner.sel(1'b0);
    @(posedge ref_clk);
    rd(OFS_FLAG_WORD, 32'h00000015);
    wr(OFS_CTRL, 32'h0000000D);
    rd(OFS_FLAG_WORD, 32'h00000005);
    wr(OFS_IRQ_CLEAR, 32'h00000001);
    irq_is(1'b0);
    $display("test mode_fault done");
    stop_test;
  end
endmodule
`default_nettype wire

// ==== sim/spi_master_model.sv ====
// Purpose: Behavioural SPI master on the slave shifter pins
// Assumes: Mode 0, 80 ns link period, clock still between frames
// Notes:   A released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  // Idle levels at time zero
  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // Select or release; the offset keeps phase apart from ref_clk
  task automatic sel(input logic on);
    #3 ss_n = !on;
    if (!on) mosi = !mosi;
    #80;
  endtask
  // One byte MSB first; miso sampled just before the falling edge
  task automatic xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi = t[i];
      #40 sck = 1'b1;
      #40 r[i] = miso;
      sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
